// file: hw/result_out_pkg.sv
// constants and register map of the result output controller
package result_out_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_NS = 1_000_000;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam int DUR_W = 10;
    localparam logic [9:0] DUR_MIN_MS = 10'h00a;
    localparam logic [9:0] DUR_MAX_MS = 10'h3de;
    localparam logic [9:0] DUR_STATIC = 10'h000;

    localparam logic [7:0] ADDR_CFG1 = 8'h00;
    localparam logic [7:0] ADDR_CFG2 = 8'h04;
    localparam logic [7:0] ADDR_FLASH = 8'h08;
    localparam logic [7:0] ADDR_STATE = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h14;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h18;

    localparam int CFG_FUNC_LSB = 0;
    localparam int CFG_INV_BIT = 3;
    localparam int CFG_DUR_LSB = 4;

    localparam logic [2:0] FN_NONE = 3'h0;
    localparam logic [2:0] FN_READY = 3'h1;
    localparam logic [2:0] FN_GOOD = 3'h2;
    localparam logic [2:0] FN_NOREAD = 3'h3;
    localparam logic [2:0] FN_FLASH = 3'h4;

    localparam logic [13:0] CFG1_RESET = 14'h0001;
    localparam logic [13:0] CFG2_RESET = 14'h0642;
    localparam logic [9:0] FLASH_RESET = 10'h00a;

    localparam int IRQ_W = 3;
    localparam int IRQ_OUT1 = 0;
    localparam int IRQ_OUT2 = 1;
    localparam int IRQ_RDEND = 2;
endpackage : result_out_pkg

// file: hw/result_out_ctrl.sv
// pulse control of the two result switching outputs with apb registers
// Notes on behaviour
// - outputs pulse for programmed time, 10 to 990 ms in ms steps
// - duration zero: output static until the next reading pulse ends
// - output one in flash function follows the flash duration
// - output one defaults to device ready, static, active low
// - output two defaults to good read, 100 ms, active high
// - device ready function holds output statically asserted while the device ready input is high
// - good read or no read event inside a reading pulse asserts only when that pulse ends
// - result lamp mirrors output two
//
// The APB slave port and the address map were left to the implementer.
module result_out_ctrl #(
    parameter int TICK_LEN = result_out_pkg::TICK_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_read_gate,
    input wire logic i_dev_ready,
    input wire logic i_good_read,
    input wire logic i_no_read,
    input wire logic i_flash_trig,
    output logic o_result1,
    output logic o_result2,
    output logic o_lamp,
    output logic o_irq
);
    import result_out_pkg::*;

    // prescaler needs at least two states to make a tick pulse
    if (TICK_LEN < 2) begin : g_bad_tick
        $error("TICK_LEN must be at least 2");
    end

    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [13:0] cfg_ff [2];
    logic [9:0] flash_ff;
    logic [IRQ_W-1:0] stat_ff;
    logic [IRQ_W-1:0] en_ff;
    logic gate_m_ff;
    logic gate_s_ff;
    logic gate_d_ff;
    logic [$clog2(TICK_LEN)-1:0] pre_ff;
    logic tick_ff;
    logic act_ff [2];
    logic pend_ff [2];
    logic stat_mode_ff [2];
    logic [9:0] cnt_ff [2];
    logic act_d_ff [2];
    logic res1_ff;
    logic res2_ff;
    logic lamp_ff;
    logic irq_ff;

    logic acc;
    logic wr_en;
    logic mapped;
    logic gate_fall;
    logic [31:0] rd_val;

    assign acc = i_psel && i_penable && !pready_ff;
    assign wr_en = i_psel && i_penable && pready_ff && i_pwrite;
    assign gate_fall = gate_d_ff && !gate_s_ff;
    assign mapped = (i_paddr == ADDR_CFG1) || (i_paddr == ADDR_CFG2) ||
                    (i_paddr == ADDR_FLASH) || (i_paddr == ADDR_STATE) ||
                    (i_paddr == ADDR_IRQ_STAT) || (i_paddr == ADDR_IRQ_CLR) ||
                    (i_paddr == ADDR_IRQ_EN);

    always_comb begin
        rd_val = 32'h0000_0000;
        case (i_paddr)
            ADDR_CFG1: rd_val = {18'h00000, cfg_ff[0]};
            ADDR_CFG2: rd_val = {18'h00000, cfg_ff[1]};
            ADDR_FLASH: rd_val = {22'h000000, flash_ff};
            ADDR_STATE: rd_val = {28'h0000000, gate_s_ff, pend_ff[1], act_ff[1], act_ff[0]};
            ADDR_IRQ_STAT: rd_val = {29'h00000000, stat_ff};
            ADDR_IRQ_EN: rd_val = {29'h00000000, en_ff};
            default: rd_val = 32'h0000_0000;
        endcase
    end

    // apb slave: one wait state, answer on the second access cycle
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pready_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= acc;
            if (acc) begin
                prdata_ff <= i_pwrite ? 32'h0000_0000 : rd_val;
                pslverr_ff <= !mapped;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cfg_ff[0] <= CFG1_RESET;
            cfg_ff[1] <= CFG2_RESET;
            flash_ff <= FLASH_RESET;
            en_ff <= '0;
        end else if (wr_en) begin
            case (i_paddr)
                ADDR_CFG1: cfg_ff[0] <= i_pwdata[13:0];
                ADDR_CFG2: cfg_ff[1] <= i_pwdata[13:0];
                ADDR_FLASH: flash_ff <= i_pwdata[9:0];
                ADDR_IRQ_EN: en_ff <= i_pwdata[IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // sticky status; a new event wins over a clear in the same cycle
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            stat_ff <= '0;
        end else begin
            stat_ff <= (stat_ff & ~((wr_en && i_paddr == ADDR_IRQ_CLR) ?
                        i_pwdata[IRQ_W-1:0] : {IRQ_W{1'b0}})) |
                       {gate_fall, act_ff[1] && !act_d_ff[1], act_ff[0] && !act_d_ff[0]};
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            gate_m_ff <= 1'b0;
            gate_s_ff <= 1'b0;
            gate_d_ff <= 1'b0;
        end else begin
            gate_m_ff <= i_read_gate;
            gate_s_ff <= gate_m_ff;
            gate_d_ff <= gate_s_ff;
        end
    end

    // millisecond timebase
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pre_ff <= '0;
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= (pre_ff == ($clog2(TICK_LEN))'(TICK_LEN - 1));
            if (pre_ff == ($clog2(TICK_LEN))'(TICK_LEN - 1)) begin
                pre_ff <= '0;
            end else begin
                pre_ff <= pre_ff + 1'b1;
            end
        end
    end

    for (genvar i = 0; i < 2; i++) begin : g_ch
        logic [2:0] func;
        logic [9:0] dur;
        logic [9:0] dur_eff;
        logic hit;
        logic launch;
        logic flash_mode;
        assign func = cfg_ff[i][CFG_FUNC_LSB +: 3];
        assign dur = cfg_ff[i][CFG_DUR_LSB +: DUR_W];
        assign dur_eff = (dur < DUR_MIN_MS) ? DUR_MIN_MS :
                         (dur > DUR_MAX_MS) ? DUR_MAX_MS : dur;
        assign hit = ((func == FN_GOOD) && i_good_read) ||
                     ((func == FN_NOREAD) && i_no_read);
        assign flash_mode = (i == 0) && (func == FN_FLASH);
        assign launch = pend_ff[i] && !gate_s_ff;

        always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
                act_ff[i] <= 1'b0;
                pend_ff[i] <= 1'b0;
                stat_mode_ff[i] <= 1'b0;
                cnt_ff[i] <= '0;
                act_d_ff[i] <= 1'b0;
            end else begin
                act_d_ff[i] <= act_ff[i];
                if (flash_mode) begin
                    pend_ff[i] <= 1'b0;
                    stat_mode_ff[i] <= 1'b0;
                    if (i_flash_trig) begin
                        act_ff[i] <= 1'b1;
                        cnt_ff[i] <= flash_ff;
                    end else if (act_ff[i] && tick_ff) begin
                        act_ff[i] <= (cnt_ff[i] > 10'h001);
                        cnt_ff[i] <= cnt_ff[i] - 10'h001;
                    end
                end else if (func == FN_READY) begin
                    pend_ff[i] <= 1'b0;
                    stat_mode_ff[i] <= 1'b1;
                    act_ff[i] <= i_dev_ready;
                end else begin
                    pend_ff[i] <= hit || (pend_ff[i] && !launch);
                    if (launch) begin
                        act_ff[i] <= 1'b1;
                        cnt_ff[i] <= dur_eff;
                        stat_mode_ff[i] <= (dur == DUR_STATIC);
                    end else if (act_ff[i] && stat_mode_ff[i]) begin
                        act_ff[i] <= !gate_fall;
                    end else if (act_ff[i] && tick_ff) begin
                        act_ff[i] <= (cnt_ff[i] > 10'h001);
                        cnt_ff[i] <= cnt_ff[i] - 10'h001;
                    end
                end
            end
        end
    end

    // pin levels: output one is low side, output two high side
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            res1_ff <= 1'b1;
            res2_ff <= 1'b0;
            lamp_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            res1_ff <= !(act_ff[0] ^ cfg_ff[0][CFG_INV_BIT]);
            res2_ff <= act_ff[1] ^ cfg_ff[1][CFG_INV_BIT];
            lamp_ff <= act_ff[1];
            irq_ff <= |(stat_ff & en_ff);
        end
    end

    assign o_prdata = prdata_ff;
    assign o_pready = pready_ff;
    assign o_pslverr = pslverr_ff;
    assign o_result1 = res1_ff;
    assign o_result2 = res2_ff;
    assign o_lamp = lamp_ff;
    assign o_irq = irq_ff;

    sequence s_launch2;
        pend_ff[1] && !gate_s_ff && cfg_ff[1][2:0] != FN_READY;
    endsequence

    a_static_hold: assert property (@(posedge i_clk) disable iff (i_rst)
        act_ff[1] && stat_mode_ff[1] && gate_s_ff && cfg_ff[1][2:0] != FN_READY
        |=> act_ff[1])
        else $error("static output dropped during reading pulse");
    a_ready_follow: assert property (@(posedge i_clk) disable iff (i_rst)
        cfg_ff[0][2:0] == FN_READY |=> act_ff[0] == $past(i_dev_ready))
        else $error("device ready output does not follow ready state");
    a_launch_gate: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(act_ff[1]) && $past(cfg_ff[1][2:0]) != FN_READY |-> !$past(gate_s_ff))
        else $error("output asserted inside reading pulse");
    a_launch_len: assert property (@(posedge i_clk) disable iff (i_rst)
        s_launch2 ##1 !stat_mode_ff[1]
        |-> cnt_ff[1] >= DUR_MIN_MS && cnt_ff[1] <= DUR_MAX_MS)
        else $error("pulse length outside 10 to 990 ms");
    a_flash_len: assert property (@(posedge i_clk) disable iff (i_rst)
        cfg_ff[0][2:0] == FN_FLASH && i_flash_trig |=> act_ff[0] && cnt_ff[0] == flash_ff)
        else $error("flash length not loaded");
    a_pin1_level: assert property (@(posedge i_clk) disable iff (i_rst)
        ##1 o_result1 == !($past(act_ff[0]) ^ $past(cfg_ff[0][CFG_INV_BIT])))
        else $error("output one level wrong");
    a_pin2_level: assert property (@(posedge i_clk) disable iff (i_rst)
        ##1 o_result2 == ($past(act_ff[1]) ^ $past(cfg_ff[1][CFG_INV_BIT])))
        else $error("output two level wrong");
    a_lamp_mirror: assert property (@(posedge i_clk) disable iff (i_rst)
        ##1 o_lamp == $past(act_ff[1]))
        else $error("lamp does not mirror output two");
    a_irq_level: assert property (@(posedge i_clk) disable iff (i_rst)
        ##1 o_irq == |($past(stat_ff) & $past(en_ff)))
        else $error("interrupt level wrong");
endmodule : result_out_ctrl

// file: tb/plc_input_model.sv
// far-side model: plc input counting active cycles and lamp watcher counting cycles where the lamp disagrees with line two
module plc_input_model (
    input wire logic i_clk,
    input wire logic i_clr,
    input wire logic i_idle2,
    input wire logic i_line1,
    input wire logic i_line2,
    input wire logic i_lamp,
    output int o_cnt1,
    output int o_cnt2,
    output int o_lamp_bad
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge i_clk) begin
        if (i_clr) begin
            o_cnt1 <= 0;
            o_cnt2 <= 0;
            o_lamp_bad <= 0;
        end else begin
            o_cnt1 <= o_cnt1 + int'(i_line1 === 1'b0);
            o_cnt2 <= o_cnt2 + int'(i_line2 !== i_idle2);
            o_lamp_bad <= o_lamp_bad + int'(i_lamp !== (i_line2 !== i_idle2));
        end
    end
endmodule : plc_input_model

// file: tb/test_result_output_pulse_control.sv
// self-checking bench of the result output controller
module test_result_output_pulse_control;
    timeunit 1ns;
    timeprecision 1ps;
    import result_out_pkg::*;
    localparam int T = 10;
    logic i_clk = 0, i_rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd, prdata;
    logic pready, pslverr, err, res1, res2, lamp, irq;
    logic gate = 0, dev = 0, good = 0, nord = 0, flash = 0, clr = 0, idle2 = 0;
    int cnt1, cnt2, lamp_bad, miscompares = 0, samples_checked = 0;
    typedef struct {logic [31:0] cfg; int ms;} row_s;
    row_s rows [7] = '{'{32'h0a2, 10}, '{32'h052, 10}, '{32'h3de2, 990},
        '{32'h3e82, 990}, '{32'h0ab, 10}, '{32'h0a4, 0}, '{32'h0a0, 0}};

    always #12.5 i_clk = ~i_clk;

    result_out_ctrl #(.TICK_LEN(T)) u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_read_gate(gate),
        .i_dev_ready(dev), .i_good_read(good), .i_no_read(nord), .i_flash_trig(flash),
        .o_result1(res1), .o_result2(res2), .o_lamp(lamp), .o_irq(irq));
    plc_input_model u_plc (.i_clk(i_clk), .i_clr(clr), .i_idle2(idle2), .i_line1(res1),
        .i_line2(res2), .i_lamp(lamp), .o_cnt1(cnt1), .o_cnt2(cnt2), .o_lamp_bad(lamp_bad));

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask : tick

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        tick(1);
        penable <= 1'b1;
        do tick(1); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        tick(1);
    endtask : apb

    task automatic fire(input logic [1:0] ev, input int n);
        clr <= 1'b1;
        tick(1);
        clr <= 1'b0;
        good <= (ev == 2'd0);
        nord <= (ev == 2'd1);
        flash <= (ev == 2'd2);
        tick(1);
        good <= 1'b0;
        nord <= 1'b0;
        flash <= 1'b0;
        tick(n);
    endtask : fire

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", n, e, g);
            miscompares++;
        end
    endtask : chk

    task automatic rng(input string n, input int ms, input int got);
        int lo;
        lo = (ms > 0) ? (ms - 1) * T : 0;
        samples_checked++;
        if (got < lo || got > ms * T + 4) begin
            $display("MISMATCH %s expected %0d seen %0d", n, ms * T, got);
            miscompares++;
        end
    endtask : rng

    task end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (60000) @(posedge i_clk);
        miscompares++;
        end_of_test();
    end

    initial begin
        tick(8);
        i_rst <= 1'b0;
        tick(1);
        chk("res1", 1, res1);
        apb(0, ADDR_CFG1, 0);
        chk("cfg1", 32'(CFG1_RESET), rd);
        apb(0, ADDR_CFG2, 0);
        chk("cfg2", 32'(CFG2_RESET), rd);
        fire(2'd0, 1040);
        rng("len2", 100, cnt2);
        foreach (rows[i]) begin
            apb(1, ADDR_CFG2, rows[i].cfg);
            idle2 <= rows[i].cfg[3];
            fire({1'b0, rows[i].cfg[0]}, rows[i].ms * T + 40);
            rng("len2", rows[i].ms, cnt2);
            chk("idle2", idle2, res2);
            chk("lamp", 0, lamp_bad);
        end
        idle2 <= 1'b0;
        apb(1, ADDR_CFG2, 32'h2);
        fire(2'd0, 30);
        chk("static", 1, res2);
        gate <= 1'b1;
        tick(10);
        chk("static", 1, res2);
        gate <= 1'b0;
        tick(6);
        chk("static", 0, res2);
        apb(1, ADDR_CFG2, 32'ha2);
        apb(1, ADDR_IRQ_EN, 32'h2);
        gate <= 1'b1;
        tick(4);
        fire(2'd0, 20);
        chk("held", 0, res2);
        gate <= 1'b0;
        tick(6);
        chk("late", 1, res2);
        chk("irq", 1, irq);
        apb(1, ADDR_IRQ_CLR, 32'h2);
        tick(2);
        chk("irq", 0, irq);
        apb(1, ADDR_IRQ_EN, 0);
        tick(1100);
        fire(2'd0, 20);
        chk("irq", 0, irq);
        apb(0, ADDR_IRQ_STAT, 0);
        chk("stat", 1, rd[1]);
        apb(1, ADDR_IRQ_EN, 32'h2);
        tick(2);
        chk("irq", 1, irq);
        apb(1, ADDR_CFG2, 32'h1);
        dev <= 1'b1;
        tick(4);
        chk("ready", 0, res1);
        chk("ready2", 1, res2);
        gate <= 1'b1;
        tick(10);
        chk("ready", 0, res1);
        chk("ready2", 1, res2);
        gate <= 1'b0;
        dev <= 1'b0;
        tick(6);
        chk("ready", 1, res1);
        chk("ready2", 0, res2);
        apb(1, ADDR_FLASH, 32'd20);
        apb(1, ADDR_CFG1, 32'h4);
        fire(2'd2, 250);
        rng("len1", 20, cnt1);
        apb(0, 8'h40, 0);
        chk("slverr", 1, err);
        chk("rdata", 0, rd);
        apb(1, ADDR_IRQ_EN, 32'h7);
        dev <= 1'b1;
        tick(3);
        chk("pre_rst_irq", 1, irq);
        chk("pre_rst_res2", 1, res2);
        i_rst <= 1'b1;
        tick(2);
        i_rst <= 1'b0;
        tick(1);
        chk("rst_res1", 1, res1);
        chk("rst_res2", 0, res2);
        chk("rst_lamp", 0, lamp);
        chk("rst_irq", 0, irq);
        tick(2);
        chk("rdy_res1", 0, res1);
        dev <= 1'b0;
        apb(0, ADDR_CFG2, 0);
        chk("rst_cfg2", 32'(CFG2_RESET), rd);
        end_of_test();
    end
endmodule : test_result_output_pulse_control
